// file: rtl/sep_page_writer.sv
// Serial EEPROM access engine with a two-dword write accumulator.
`timescale 1ns/100ps
module sep_page_writer #(
	parameter int TWC_CYCLES = sep_pkg::TWC_CYC
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic host_req,
	input wire sep_pkg::sep_req_s host_acc,
	output logic host_ready,
	output logic host_retry,
	output logic host_denied,
	output logic host_rvalid,
	output logic [31:0] host_rdata,
	input wire logic biosboot_strap,
	output logic eeprom_sck,
	output logic eeprom_cs_n,
	output logic eeprom_mosi,
	input wire logic eeprom_miso
);
	// =========================================================
	// Decoding helpers
	function automatic logic [1:0] first_lane(input logic [3:0] m);
		first_lane = 2'h0;
		for (int i = 3; i >= 0; i--)
			if (m[i])
				first_lane = 2'(i);
	endfunction

	function automatic logic at_edge(input logic [15:0] a, input logic big);
		logic [4:0] m;
		m = big ? sep_pkg::PG_BIG : sep_pkg::PG_SMALL;
		at_edge = (a[6:2] & m) == m;
	endfunction

	// =========================================================
	// State
	logic strap_s1_q, strap_s2_q, miso_s1_q, miso_s2_q;
	logic [1:0] cap_q;
	logic biosen_q, romen_q, map_q, wt_q, noretry_q, big_q;
	sep_pkg::sep_req_s fifo_q [2];
	logic [1:0] cnt_q;
	sep_pkg::sep_st_e st_q, st_d;
	logic page_q, wr_q, ld_q, sck_q, cs_n_q;
	logic [1:0] lane_q;
	logic [3:0] sent_q, div_q;
	logic [2:0] bitc_q;
	logic [7:0] sh_q, rx_q, tx;
	logic [15:0] addr_q;
	logic [31:0] rdata_q, reg_rdata_q, ctrl_w, stat_w;
	logic [20:0] twc_q;
	logic [6:0] hold_q;
	logic retry_q, denied_q, rvalid_q;
	sep_pkg::sep_req_s h, n;

	// =========================================================
	// Host side decode
	wire acc_en = biosen_q && romen_q && map_q;
	wire acc_ok = acc_en && (!host_acc.we || wt_q);
	assign host_ready = cnt_q != sep_pkg::ACC_DEPTH;
	wire push = host_req && host_ready && acc_ok;
	assign h = fifo_q[0];
	assign n = fifo_q[1];
	wire [3:0] rem = h.be & ~sent_q;
	wire [1:0] first = first_lane(rem);
	wire consec = n.we && n.be == sep_pkg::BE_ALL && n.addr == h.addr + sep_pkg::DW_STEP;
	wire full_acc = cnt_q == sep_pkg::ACC_DEPTH;
	wire page_ok = full_acc && h.we && h.be == sep_pkg::BE_ALL && consec;
	wire edge_dw = at_edge(h.addr, big_q);
	wire cont = page_q && !edge_dw && full_acc && consec;
	wire hold_done = hold_q == 7'(sep_pkg::HOLD_CYC);
	wire go = !h.we || h.be != sep_pkg::BE_ALL || full_acc || hold_done;

	// =========================================================
	// Serial engine decode
	wire tick = div_q == 4'(sep_pkg::SCK_HALF - 1);
	wire sending = st_q == sep_pkg::S_WREN || st_q == sep_pkg::S_CMD || st_q == sep_pkg::S_AHI
		|| st_q == sep_pkg::S_ALO || st_q == sep_pkg::S_DATA;
	wire byte_done = ld_q && tick && sck_q && bitc_q == 3'h7;
	wire [3:0] rem_nx = rem & ~(4'h1 << lane_q);
	wire run_on = lane_q != 2'h3 && rem_nx[lane_q + 2'h1];
	wire data_end = st_q == sep_pkg::S_DATA && byte_done && rem_nx == 4'h0;
	wire idle_skip = st_q == sep_pkg::S_IDLE && cnt_q != 2'h0 && rem == 4'h0;
	wire pop = idle_skip || data_end;
	wire start = st_q == sep_pkg::S_IDLE && cnt_q != 2'h0 && rem != 4'h0 && go;
	wire twc_done = twc_q == 21'(TWC_CYCLES - 1);

	always_comb
	begin
		case (st_q)
			sep_pkg::S_WREN: tx = sep_pkg::OP_WREN;
			sep_pkg::S_CMD: tx = wr_q ? sep_pkg::OP_WRITE : sep_pkg::OP_READ;
			sep_pkg::S_AHI: tx = addr_q[15:8];
			sep_pkg::S_ALO: tx = addr_q[7:0];
			sep_pkg::S_DATA: tx = wr_q ? h.data[{lane_q, 3'h0} +: 8] : 8'h00;
			default: tx = 8'h00;
		endcase
	end

	always_comb
	begin
		st_d = st_q;
		case (st_q)
			sep_pkg::S_IDLE:
				if (start)
					st_d = h.we ? sep_pkg::S_WREN : sep_pkg::S_CMD;
			sep_pkg::S_WREN:
				if (byte_done)
					st_d = sep_pkg::S_GAP;
			sep_pkg::S_GAP:
				if (tick)
					st_d = sep_pkg::S_CMD;
			sep_pkg::S_CMD:
				if (byte_done)
					st_d = big_q ? sep_pkg::S_AHI : sep_pkg::S_ALO;
			sep_pkg::S_AHI:
				if (byte_done)
					st_d = sep_pkg::S_ALO;
			sep_pkg::S_ALO:
				if (byte_done)
					st_d = sep_pkg::S_DATA;
			sep_pkg::S_DATA:
				if (byte_done && !run_on && !(data_end && cont))
					st_d = sep_pkg::S_END;
			sep_pkg::S_END:
				if (tick)
					st_d = wr_q ? sep_pkg::S_TWC : sep_pkg::S_IDLE;
			sep_pkg::S_TWC:
				if (twc_done)
					st_d = sep_pkg::S_IDLE;
			default: st_d = sep_pkg::S_IDLE;
		endcase
	end

	// =========================================================
	// Register view
	always_comb
	begin
		ctrl_w = 32'h0;
		ctrl_w[sep_pkg::CB_BIOSEN] = biosen_q;
		ctrl_w[sep_pkg::CB_ROMEN] = romen_q;
		ctrl_w[sep_pkg::CB_MAP] = map_q;
		ctrl_w[sep_pkg::CB_WT] = wt_q;
		ctrl_w[sep_pkg::CB_NORETRY] = noretry_q;
		stat_w = 32'h0;
		stat_w[sep_pkg::SB_BIG] = big_q;
		stat_w[sep_pkg::SB_BUSY] = st_q != sep_pkg::S_IDLE;
		stat_w[sep_pkg::SB_TWC] = st_q == sep_pkg::S_TWC;
		stat_w[sep_pkg::SB_CNT +: 2] = cnt_q;
	end
	wire [31:0] rd_mux = reg_addr == sep_pkg::REG_CTRL ? ctrl_w
		: reg_addr == sep_pkg::REG_STAT ? stat_w : 32'h0;
	wire ctrl_wr = reg_wr && reg_addr == sep_pkg::REG_CTRL;

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			strap_s1_q <= 1'b0;
			strap_s2_q <= 1'b0;
			miso_s1_q <= 1'b0;
			miso_s2_q <= 1'b0;
			cap_q <= 2'h0;
			reg_rdata_q <= 32'h0;
		end
		else
		begin
			strap_s1_q <= biosboot_strap;
			strap_s2_q <= strap_s1_q;
			miso_s1_q <= eeprom_miso;
			miso_s2_q <= miso_s1_q;
			cap_q <= cap_q + {1'b0, cap_q != 2'h3};
			reg_rdata_q <= reg_rd ? rd_mux : 32'h0;
		end
	end

	// The size strap is caught once the synchroniser has settled.
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			{biosen_q, romen_q, map_q, wt_q, noretry_q, big_q} <= 6'h00;
		end
		else if (cap_q == 2'h2)
		begin
			biosen_q <= strap_s2_q;
			big_q <= strap_s2_q;
		end
		else if (ctrl_wr)
		begin
			biosen_q <= reg_wdata[sep_pkg::CB_BIOSEN];
			romen_q <= reg_wdata[sep_pkg::CB_ROMEN];
			map_q <= reg_wdata[sep_pkg::CB_MAP];
			wt_q <= reg_wdata[sep_pkg::CB_WT];
			noretry_q <= reg_wdata[sep_pkg::CB_NORETRY];
		end
	end

	// =========================================================
	// Accumulator; a lone full-dword write waits briefly for a partner.
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			fifo_q[0] <= '0;
			fifo_q[1] <= '0;
			cnt_q <= 2'h0;
			hold_q <= 7'h00;
			retry_q <= 1'b0;
			denied_q <= 1'b0;
		end
		else
		begin
			if (pop)
				fifo_q[0] <= (push && cnt_q == 2'h1) ? host_acc : fifo_q[1];
			else if (push)
				fifo_q[cnt_q[0]] <= host_acc;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
			hold_q <= (st_q == sep_pkg::S_IDLE && cnt_q == 2'h1) ? hold_q + {6'h00, !hold_done} : 7'h00;
			retry_q <= host_req && !host_ready && acc_ok && !noretry_q;
			denied_q <= host_req && !acc_ok;
		end
	end

	// =========================================================
	// Transfer sequencing
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			st_q <= sep_pkg::S_IDLE;
			page_q <= 1'b0;
			wr_q <= 1'b0;
			lane_q <= 2'h0;
			addr_q <= 16'h0000;
			sent_q <= 4'h0;
			rdata_q <= 32'h0;
			rvalid_q <= 1'b0;
			twc_q <= 21'h0;
		end
		else
		begin
			st_q <= st_d;
			rvalid_q <= pop && !h.we;
			twc_q <= st_q == sep_pkg::S_TWC ? twc_q + 21'h1 : 21'h0;
			if (pop)
				sent_q <= 4'h0;
			else if (st_q == sep_pkg::S_DATA && byte_done)
				sent_q <= sent_q | (4'h1 << lane_q);
			if (start)
			begin
				page_q <= page_ok;
				wr_q <= h.we;
				lane_q <= first;
				addr_q <= {h.addr[15:2], first};
				if (sent_q == 4'h0)
					rdata_q <= 32'h0;
			end
			else if (st_q == sep_pkg::S_DATA && byte_done)
			begin
				lane_q <= run_on ? lane_q + 2'h1 : 2'h0;
				if (!wr_q)
					rdata_q[{lane_q, 3'h0} +: 8] <= rx_q;
			end
			else if (st_q == sep_pkg::S_END)
				page_q <= 1'b0;
		end
	end

	// =========================================================
	// Serial shifter, mode 0: data moves on the falling edge.
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			ld_q <= 1'b0;
			sck_q <= 1'b0;
			cs_n_q <= 1'b1;
			bitc_q <= 3'h0;
			sh_q <= 8'h00;
			rx_q <= 8'h00;
			div_q <= 4'h0;
		end
		else
		begin
			cs_n_q <= !sending;
			div_q <= (tick || (sending && !ld_q)) ? 4'h0 : div_q + 4'h1;
			if (sending && !ld_q)
			begin
				ld_q <= 1'b1;
				sh_q <= tx;
				bitc_q <= 3'h0;
			end
			else if (ld_q && tick && !sck_q)
			begin
				sck_q <= 1'b1;
				rx_q <= {rx_q[6:0], miso_s2_q};
			end
			else if (ld_q && tick)
			begin
				sck_q <= 1'b0;
				ld_q <= bitc_q != 3'h7;
				sh_q <= {sh_q[6:0], 1'b0};
				bitc_q <= bitc_q + 3'h1;
			end
		end
	end

	assign reg_rdata = reg_rdata_q;
	assign host_retry = retry_q;
	assign host_denied = denied_q;
	assign host_rvalid = rvalid_q;
	assign host_rdata = rdata_q;
	assign eeprom_sck = sck_q;
	assign eeprom_cs_n = cs_n_q;
	assign eeprom_mosi = sh_q[7];

	// =========================================================
	// Checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	AST_GATE: assert property (host_req && !acc_en |=> host_denied && $stable(cnt_q) || pop)
		else $error("access taken while the ROM window is closed");
	AST_WLOCK: assert property (host_req && host_acc.we && !wt_q |=> host_denied)
		else $error("write not refused while locked");
	AST_DEPTH: assert property (cnt_q <= sep_pkg::ACC_DEPTH)
		else $error("accumulator holds more than two dwords");
	AST_PAGE_START: assert property ($rose(page_q) |-> $past(cnt_q) == 2'h2 && $past(h.we) && $past(n.we))
		else $error("page write started without two full writes");
	AST_PAGE_END: assert property (data_end && page_q && edge_dw |=> st_q == sep_pkg::S_END)
		else $error("page write ran past its boundary");
	AST_TWC_QUIET: assert property (st_q == sep_pkg::S_TWC |-> eeprom_cs_n && !eeprom_sck)
		else $error("serial traffic during the write cycle time");
	AST_TWC_ENTRY: assert property (st_q == sep_pkg::S_END && tick && wr_q |=> st_q == sep_pkg::S_TWC [*8])
		else $error("write cycle wait cut short");
	AST_RETRY: assert property (host_req && !host_ready && acc_ok && !noretry_q |=> host_retry)
		else $error("missing retry on a full accumulator");
	AST_NORETRY: assert property (host_retry |-> !$past(noretry_q))
		else $error("retry given with the no-retry bit set");
	AST_SCK_HIGH: assert property ($rose(eeprom_sck) |-> eeprom_sck [*8])
		else $error("serial clock high phase too short");
	AST_SCK_LOW: assert property ($fell(eeprom_sck) |-> !eeprom_sck [*8])
		else $error("serial clock low phase too short");
endmodule

// file: rtl/sep_pkg.sv
// Constants and types shared by the serial EEPROM page writer.
package sep_pkg;
	// =========================================================
	// Timing
	localparam int CLK_NS = 8;
	localparam int SCK_MAX_KHZ = 5000;
	localparam int SCK_HALF = (500000 / SCK_MAX_KHZ + CLK_NS) / CLK_NS;
	localparam int TWC_US = 10000;
	localparam int TWC_CYC = TWC_US * 1000 / CLK_NS;
	localparam int HOLD_CYC = 64;
	// =========================================================
	// Registers and fields
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam int CB_BIOSEN = 0;
	localparam int CB_ROMEN = 1;
	localparam int CB_MAP = 2;
	localparam int CB_WT = 3;
	localparam int CB_NORETRY = 4;
	localparam int SB_BIG = 0;
	localparam int SB_BUSY = 1;
	localparam int SB_TWC = 2;
	localparam int SB_CNT = 4;
	// =========================================================
	// Serial commands and page geometry
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRITE = 8'h02;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [4:0] PG_SMALL = 5'h03;
	localparam logic [4:0] PG_BIG = 5'h1f;
	localparam logic [15:0] DW_STEP = 16'h0004;
	localparam logic [3:0] BE_ALL = 4'hf;
	localparam logic [1:0] ACC_DEPTH = 2'h2;
	// =========================================================
	// Types
	typedef struct packed {
		logic we;
		logic [15:0] addr;
		logic [3:0] be;
		logic [31:0] data;
	} sep_req_s;
	typedef enum logic [3:0] {
		S_IDLE, S_WREN, S_GAP, S_CMD, S_AHI, S_ALO, S_DATA, S_END, S_TWC
	} sep_st_e;
endpackage

// file: verif/sep_eeprom_model.sv
// Behavioural serial EEPROM with a write-enable latch and its own page wrap.
`timescale 1ns/100ps
module sep_eeprom_model #(
	parameter int ABYTES = 2,
	parameter int PAGE = 64
) (
	input wire logic sck,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso
);
	logic [7:0] mem [0:65535];
	logic [7:0] sh;
	logic [7:0] op;
	logic [15:0] a;
	logic [15:0] pmask;
	logic wel;
	int bits;
	initial
	begin
		for (int i = 0; i < 65536; i++)
			mem[i] = ~i[7:0];
		pmask = 16'(PAGE - 1);
		op = 8'h00;
		wel = 1'b0;
		miso = 1'b0;
		bits = 0;
	end
	// ==========================================
	// Frame decode
	always @(negedge cs_n)
		bits = 0;
	// The released line shows the inverse of its last value, and a write frame clears the latch.
	always @(posedge cs_n)
	begin
		if (op == sep_pkg::OP_WRITE)
			wel = 1'b0;
		miso = ~miso;
	end
	always @(posedge sck)
	if (!cs_n)
	begin
		sh = {sh[6:0], mosi};
		bits++;
		if (bits % 8 == 0)
		begin
			if (bits == 8)
			begin
				op = sh;
				if (op == sep_pkg::OP_WREN)
					wel = 1'b1;
			end
			else if (bits <= 8 * (1 + ABYTES))
				a = {a[7:0], sh};
			else if (op == sep_pkg::OP_WRITE)
			begin
				if (wel)
					mem[a] = sh;
				// A write that runs past the part's own page wraps to its start.
				a = (a & ~pmask) | ((a + 16'h1) & pmask);
			end
			else
				a = a + 16'h1;
		end
	end
	always @(negedge sck)
	if (!cs_n && op == sep_pkg::OP_READ && bits >= 8 * (1 + ABYTES))
		miso = mem[a][7 - bits % 8];
endmodule

// file: verif/sep_page_writer_tb.sv
// Self-checking bench for the serial EEPROM page writer.
`timescale 1ns/100ps
module sep_page_writer_tb;
	localparam int PAGE = 64;
	logic clk_sys, resetn, reg_wr, reg_rd, rd_seen, host_req, biosboot_strap;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, host_rdata;
	sep_pkg::sep_req_s host_acc;
	logic host_ready, host_retry, host_denied, host_rvalid;
	logic eeprom_sck, eeprom_cs_n, eeprom_mosi, eeprom_miso;
	logic [7:0] shadow [0:65535];
	logic [63:0] reg_q[$];
	logic [63:0] host_q[$];
	logic [63:0] he, re;
	logic [31:0] d0, d1;
	int err_total, comparisons;
	realtime sck_last;
	sep_page_writer #(.TWC_CYCLES(50)) sep_page_writer_inst (.clk_sys(clk_sys), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.host_req(host_req), .host_acc(host_acc), .host_ready(host_ready), .host_retry(host_retry),
		.host_denied(host_denied), .host_rvalid(host_rvalid), .host_rdata(host_rdata),
		.biosboot_strap(biosboot_strap), .eeprom_sck(eeprom_sck), .eeprom_cs_n(eeprom_cs_n),
		.eeprom_mosi(eeprom_mosi), .eeprom_miso(eeprom_miso));
	sep_eeprom_model #(.ABYTES(2), .PAGE(PAGE)) sep_eeprom_model_inst (.sck(eeprom_sck), .cs_n(eeprom_cs_n),
		.mosi(eeprom_mosi), .miso(eeprom_miso));
	// ==========================================
	// Checking and bus tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run();
		if (err_total == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic reg_access(input logic wr, input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= wr;
		reg_rd <= !wr;
		if (!wr)
			reg_q.push_back({m, v});
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
	endtask
	function automatic logic [31:0] lanes(input logic [3:0] be);
		return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction
	function automatic logic [31:0] exp_dw(input logic [15:0] a);
		return {shadow[a + 16'h3], shadow[a + 16'h2], shadow[a + 16'h1], shadow[a]};
	endfunction
	// Mode 0 waits for room, mode 1 expects a gating refusal, mode 2 expects a retry.
	task automatic host_op(input logic we, input logic [15:0] a, input logic [3:0] be, input logic [31:0] v,
		input int mode);
		int n;
		host_acc <= '{we: we, addr: a, be: be, data: v};
		host_req <= 1'b1;
		for (n = 0; n < 20000; n++)
		begin
			@(posedge clk_sys);
			if (host_ready === 1'b1 || mode == 2)
				break;
		end
		host_req <= 1'b0;
		if (n == 20000)
		begin
			err_total++;
			complete_run();
		end
		@(posedge clk_sys);
		check("host_denied", host_denied, mode == 1);
		check("host_retry", host_retry, mode == 2);
	endtask
	task automatic wr_dw(input logic [15:0] a, input logic [3:0] be, input logic [31:0] v);
		host_op(1'b1, a, be, v, 0);
		for (int i = 0; i < 4; i++)
			if (be[i])
				shadow[a + 16'(i)] = v[8 * i +: 8];
	endtask
	task automatic rd_dw(input logic [15:0] a, input logic [3:0] be);
		host_q.push_back({lanes(be), exp_dw(a) & lanes(be)});
		host_op(1'b0, a, be, 32'h0, 0);
	endtask
	task automatic wait_drain();
		for (int n = 0; n < 40000 && host_q.size() > 0; n++)
			@(posedge clk_sys);
		if (host_q.size() > 0)
		begin
			err_total++;
			complete_run();
		end
	endtask
	// ==========================================
	// Monitors
	// Outputs are looked at mid-cycle, where registered values have settled.
	always @(negedge clk_sys)
	begin
		if (host_rvalid === 1'b1)
		begin
			if (host_q.size() == 0)
				check("host_rvalid", 1'b1, 1'b0);
			else
			begin
				he = host_q.pop_front();
				check("host_rdata", host_rdata & he[63:32], he[31:0]);
			end
		end
		if (rd_seen === 1'b1)
		begin
			re = reg_q.pop_front();
			check("reg_rdata", reg_rdata & re[63:32], re[31:0]);
		end
		rd_seen <= reg_rd;
	end
	always @(posedge eeprom_sck)
	begin
		if (sck_last > 0.0)
			check("sck_period_short", ($realtime - sck_last) < 200.0, 1'b0);
		sck_last = $realtime;
	end
	// ==========================================
	// Main sequence
	initial
	begin
		clk_sys = 1'b0;
		forever
			#4 clk_sys = ~clk_sys;
	end
	initial
	begin
		{resetn, reg_wr, reg_rd, rd_seen, host_req, reg_addr, reg_wdata} = '0;
		host_acc = '0;
		biosboot_strap = 1'b1;
		sck_last = 0.0;
		for (int i = 0; i < 65536; i++)
			shadow[i] = ~i[7:0];
		void'($urandom(99241));
		repeat (16) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		reg_access(1'b0, sep_pkg::REG_STAT, 32'h1, 32'h1);
		reg_access(1'b0, sep_pkg::REG_CTRL, 32'h1, 32'h1f);
		reg_access(1'b0, 8'h08, 32'h0, 32'hffffffff);
		reg_access(1'b1, sep_pkg::REG_CTRL, 32'h1, 32'h0);
		host_op(1'b0, 16'h0010, 4'hf, 32'h0, 1);
		reg_access(1'b1, sep_pkg::REG_CTRL, 32'h7, 32'h0);
		host_op(1'b1, 16'h0010, 4'hf, 32'h12345678, 1);
		reg_access(1'b1, sep_pkg::REG_CTRL, 32'h1f, 32'h0);
		// Sizing pair: the part's 64-byte page wraps the second dword onto 0x00.
		d0 = $urandom;
		d1 = $urandom;
		host_op(1'b1, 16'h003c, 4'hf, d0, 0);
		host_op(1'b1, 16'h0040, 4'hf, d1, 0);
		for (int i = 0; i < 4; i++)
		begin
			shadow[16'h003c + i] = d0[8 * i +: 8];
			shadow[i] = d1[8 * i +: 8];
		end
		rd_dw(16'h0040, 4'hf);
		rd_dw(16'h0000, 4'hf);
		for (int i = 0; i < 4; i++)
			wr_dw(16'h0078 + 16'(4 * i), 4'hf, $urandom);
		for (int i = 0; i < 4; i++)
			rd_dw(16'h0078 + 16'(4 * i), 4'hf);
		rd_dw(16'h0040, 4'hf);
		// Page blocks are written from the top down, never in ascending block order.
		for (int i = 0; i < 2; i++)
		begin
			wr_dw(16'h00c8 - 16'(8 * i), 4'hf, $urandom);
			wr_dw(16'h00cc - 16'(8 * i), 4'hf, $urandom);
		end
		for (int i = 0; i < 4; i++)
			rd_dw(16'h00c0 + 16'(4 * i), 4'hf);
		wr_dw(16'h0100, 4'h5, $urandom);
		rd_dw(16'h0100, 4'hf);
		rd_dw(16'h0100, 4'h6);
		rd_dw(16'h0104, 4'h9);
		wait_drain();
		reg_access(1'b1, sep_pkg::REG_CTRL, 32'hf, 32'h0);
		wr_dw(16'h0200, 4'h1, $urandom);
		wr_dw(16'h0204, 4'h2, $urandom);
		host_op(1'b1, 16'h0208, 4'hf, 32'hffffffff, 2);
		reg_access(1'b0, sep_pkg::REG_STAT, 32'h20, 32'h30);
		rd_dw(16'h0208, 4'hf);
		wait_drain();
		complete_run();
	end
endmodule
